// ===== src/wake_cfg_map.svh
// Constants for the wake and interface configuration register.
// Assumes a 16-bit management register file addressed by 5-bit register number.
`ifndef WAKE_CFG_MAP_SVH
`define WAKE_CFG_MAP_SVH

`define CFG1_ADDR            5'h12
`define CFG1_BIT_ROLE        15
`define CFG1_BIT_LOC_FWD     14
`define CFG1_BIT_REM_REACT   11
`define CFG1_BIT_LOC_REACT   10
`define CFG1_MODE_HI         9
`define CFG1_MODE_LO         8
`define CFG1_BIT_DRIVE       7
`define CFG1_BIT_CONFIRM     6
`define CFG1_BIT_LPS_DIS     5
`define CFG1_BIT_ACK         4
`define CFG1_BIT_REM_FWD     2
`define CFG1_BIT_AUTO_PWD    1
`define CFG1_BIT_LPS_ACTIVE  0
// Writable-bit mask: reserved 13:12 and 3 excluded
`define CFG1_WMASK           16'hcff7
// Fixed reset bits (strap fields zero here): 14, 11, 10, 0
`define CFG1_RST_FIXED       16'h4c01
// Wake detection activation time in ns and its cycle count at 40 MHz
`define WAKE_DET_TIME_NS     1000
`define CLK_PERIOD_NS        25
`define WAKE_DET_CYCLES      ((`WAKE_DET_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== src/wake_cfg_pkg.sv
// Types for the wake and interface configuration register.
// Assumes the map header for numeric constants.
package wake_cfg_pkg;
  typedef enum logic [1:0]
  {
    HOST_MII        = 2'h0,
    HOST_RMII_IN50  = 2'h1,
    HOST_RMII_OUT25 = 2'h2,
    HOST_REV_MII    = 2'h3
  } host_if_e;

  typedef enum logic [1:0]
  {
    ARM_IDLE = 2'h0,
    ARM_WAIT = 2'h1,
    ARM_LIVE = 2'h3
  } arm_state_e;
endpackage

// ===== src/wake_arm_if.sv
// Carrier between the register bank and the wake arming timer.
// Assumes one clock domain.
`timescale 1ns/100ps
interface wake_arm_if;
  logic react_en;
  logic armed;
  modport bank  (output react_en, input armed);
  modport timer (input react_en, output armed);
endinterface

// ===== src/wake_arm_timer.sv
// Local wake arming timer: detection goes live a fixed time after enable.
// Assumes synchronous active-high reset.
`include "wake_cfg_map.svh"
`timescale 1ns/100ps
module wake_arm_timer
  import wake_cfg_pkg::*;
(
  input  wire logic   clk_in,
  input  wire logic   sys_rst_in,
  wake_arm_if.timer   arm
);
  localparam int      CNT_MAX = `WAKE_DET_CYCLES;
  arm_state_e         state_q, state_d;
  logic [7:0]         cnt_q, cnt_d;

  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      ARM_IDLE:
      begin
        cnt_d = 8'h00;
        if (arm.react_en)
          state_d = ARM_WAIT;
      end
      ARM_WAIT:
      begin
        if (!arm.react_en)
          state_d = ARM_IDLE;
        else if (cnt_q == 8'(CNT_MAX - 1))
          state_d = ARM_LIVE;
        else
          cnt_d = cnt_q + 8'h01;
      end
      ARM_LIVE:
        if (!arm.react_en)
          state_d = ARM_IDLE;
      default:
        state_d = ARM_IDLE;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      state_q <= ARM_IDLE;
      cnt_q   <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  assign arm.armed = (state_q == ARM_LIVE);

  property p_arm_delay;
    @(posedge clk_in) disable iff (sys_rst_in)
      $rose(arm.react_en) && state_q == ARM_IDLE |-> !arm.armed [*8];
  endproperty
  a_arm_delay: assert property (p_arm_delay) else $error("wake armed too early");
endmodule // wake_arm_timer

// ===== src/wake_cfg_reg.sv
// Wake and interface configuration register with its decoded controls.
// Assumes a management front end giving single-cycle write and read strobes.
`include "wake_cfg_map.svh"
`timescale 1ns/100ps
module wake_cfg_reg
  import wake_cfg_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic [4:0]        reg_addr_in,
  input  wire logic              reg_wr_in,
  input  wire logic [15:0]       reg_wdata_in,
  input  wire logic              reg_rd_in,
  input  wire logic              strap_master_in,
  input  wire wake_cfg_pkg::host_if_e strap_host_if_in,
  input  wire logic              local_wake_in,
  input  wire logic              remote_wake_in,
  input  wire logic              sleep_req_mode_in,
  input  wire logic              traffic_in,
  output logic [15:0]            reg_rdata_out,
  output logic                   reg_rvalid_out,
  output logic                   master_role_out,
  output wake_cfg_pkg::host_if_e host_if_out,
  output logic                   ref_clk_out_en_out,
  output logic                   reduced_drive_out,
  output logic                   sleep_peer_confirm_required_out,
  output logic                   low_power_symbol_disable_out,
  output logic                   sleep_ack_timer_run_out,
  output logic                   auto_pwd_out,
  output logic                   lps_active_out,
  output logic                   local_wake_event_out,
  output logic                   remote_wake_event_out,
  output logic                   local_wake_forward_out,
  output logic                   remote_wake_forward_out,
  output logic                   traffic_return_normal_out
);
  import wake_cfg_pkg::*;

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic [15:0] cfg_q, cfg_d;
  logic        strap_done_q, strap_done_d;
  logic [15:0] rdata_q, rdata_d;
  logic        rvalid_q, rvalid_d;
  logic        hit;
  wake_arm_if  arm ();

  assign hit = (reg_addr_in == `CFG1_ADDR);

  always_comb
  begin
    cfg_d        = cfg_q;
    strap_done_d = 1'b1;
    rdata_d      = rdata_q;
    rvalid_d     = reg_rd_in;
    if (!strap_done_q)
    begin
      cfg_d[`CFG1_BIT_ROLE]                 = strap_master_in;
      cfg_d[`CFG1_MODE_HI:`CFG1_MODE_LO]    = strap_host_if_in;
    end
    else if (reg_wr_in && hit)
      cfg_d = reg_wdata_in & `CFG1_WMASK;
    if (reg_rd_in)
      rdata_d = hit ? (cfg_q & `CFG1_WMASK) : 16'h0000;
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      cfg_q        <= `CFG1_RST_FIXED;
      strap_done_q <= 1'b0;
      rdata_q      <= 16'h0000;
      rvalid_q     <= 1'b0;
    end
    else
    begin
      cfg_q        <= cfg_d;
      strap_done_q <= strap_done_d;
      rdata_q      <= rdata_d;
      rvalid_q     <= rvalid_d;
    end
  end

  // ---------------------------------------------------------------
  // Local wake arming
  // ---------------------------------------------------------------
  // local reaction enable feeds arming
  assign arm.react_en = cfg_q[`CFG1_BIT_LOC_REACT];
  wake_arm_timer u_arm
  (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .arm        (arm)
  );

  // ---------------------------------------------------------------
  // Decoded controls, all registered
  // ---------------------------------------------------------------
  logic [15:0] ctl_q, ctl_d;
  host_if_e    host_q, host_d;

  always_comb
  begin
    ctl_d  = 16'h0000;
    ctl_d[0]  = cfg_q[`CFG1_BIT_ROLE];
    host_d    = host_if_e'(cfg_q[`CFG1_MODE_HI:`CFG1_MODE_LO]);
    ctl_d[1]  = (host_d == HOST_RMII_OUT25);
    ctl_d[2]  = cfg_q[`CFG1_BIT_DRIVE];
    ctl_d[3]  = cfg_q[`CFG1_BIT_CONFIRM];
    ctl_d[4]  = cfg_q[`CFG1_BIT_LPS_DIS];
    ctl_d[5]  = cfg_q[`CFG1_BIT_ACK];
    ctl_d[6]  = cfg_q[`CFG1_BIT_AUTO_PWD];
    ctl_d[7]  = cfg_q[`CFG1_BIT_LPS_ACTIVE];
    // local wake gated and armed
    // Bit 10 gates directly: the timer leaves its live state one cycle late
    ctl_d[8]  = local_wake_in && arm.armed && cfg_q[`CFG1_BIT_LOC_REACT];
    ctl_d[9]  = remote_wake_in && cfg_q[`CFG1_BIT_REM_REACT];
    ctl_d[10] = local_wake_in && arm.armed && cfg_q[`CFG1_BIT_LOC_REACT]
                && cfg_q[`CFG1_BIT_LOC_FWD];
    ctl_d[11] = remote_wake_in && cfg_q[`CFG1_BIT_REM_REACT] && cfg_q[`CFG1_BIT_REM_FWD];
    // traffic return only with timer off
    ctl_d[12] = sleep_req_mode_in && traffic_in && !cfg_q[`CFG1_BIT_ACK];
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      ctl_q  <= 16'h0000;
      host_q <= HOST_MII;
    end
    else
    begin
      ctl_q  <= ctl_d;
      host_q <= host_d;
    end
  end

  assign reg_rdata_out                   = rdata_q;
  assign reg_rvalid_out                  = rvalid_q;
  assign master_role_out                 = ctl_q[0];
  assign host_if_out                     = host_q;
  assign ref_clk_out_en_out              = ctl_q[1];
  assign reduced_drive_out               = ctl_q[2];
  assign sleep_peer_confirm_required_out = ctl_q[3];
  assign low_power_symbol_disable_out    = ctl_q[4];
  assign sleep_ack_timer_run_out         = ctl_q[5];
  assign auto_pwd_out                    = ctl_q[6];
  assign lps_active_out                  = ctl_q[7];
  assign local_wake_event_out            = ctl_q[8];
  assign remote_wake_event_out           = ctl_q[9];
  assign local_wake_forward_out          = ctl_q[10];
  assign remote_wake_forward_out         = ctl_q[11];
  assign traffic_return_normal_out       = ctl_q[12];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_role;
    @(posedge clk_in) disable iff (sys_rst_in)
      strap_done_q |=> master_role_out == $past(cfg_q[`CFG1_BIT_ROLE]);
  endproperty
  a_role: assert property (p_role) else $error("role mismatch");

  property p_loc_fwd;
    @(posedge clk_in) disable iff (sys_rst_in)
      !cfg_q[`CFG1_BIT_LOC_FWD] |=> !local_wake_forward_out;
  endproperty
  a_loc_fwd: assert property (p_loc_fwd) else $error("local forward while off");

  property p_rem_react;
    @(posedge clk_in) disable iff (sys_rst_in)
      remote_wake_in && cfg_q[`CFG1_BIT_REM_REACT] |=> remote_wake_event_out;
  endproperty
  a_rem_react: assert property (p_rem_react) else $error("remote wake lost");

  property p_loc_react;
    @(posedge clk_in) disable iff (sys_rst_in)
      !cfg_q[`CFG1_BIT_LOC_REACT] |=> !local_wake_event_out;
  endproperty
  a_loc_react: assert property (p_loc_react) else $error("local wake while off");

  property p_host;
    @(posedge clk_in) disable iff (sys_rst_in)
      1'b1 |=> host_if_out == $past(cfg_q[`CFG1_MODE_HI:`CFG1_MODE_LO])
               && ref_clk_out_en_out == ($past(cfg_q[`CFG1_MODE_HI:`CFG1_MODE_LO]) == 2'h2);
  endproperty
  a_host: assert property (p_host) else $error("ref clock enable wrong");

  // Accepted write, then the cycle in which the decoded controls load
  sequence s_cfg_write;
    reg_wr_in && hit && strap_done_q ##1 1'b1;
  endsequence

  property p_drive;
    @(posedge clk_in) disable iff (sys_rst_in)
      s_cfg_write |=> reduced_drive_out == $past(reg_wdata_in[7], 2);
  endproperty
  a_drive: assert property (p_drive) else $error("drive not updated");

  property p_ack_off;
    @(posedge clk_in) disable iff (sys_rst_in)
      sleep_req_mode_in && traffic_in && !cfg_q[`CFG1_BIT_ACK] |=> traffic_return_normal_out;
  endproperty
  a_ack_off: assert property (p_ack_off) else $error("no return to normal");

  property p_ack_on;
    @(posedge clk_in) disable iff (sys_rst_in)
      cfg_q[`CFG1_BIT_ACK] |=> !traffic_return_normal_out;
  endproperty
  a_ack_on: assert property (p_ack_on) else $error("return with ack timer");

  property p_rem_fwd;
    @(posedge clk_in) disable iff (sys_rst_in)
      !cfg_q[`CFG1_BIT_REM_FWD] |=> !remote_wake_forward_out;
  endproperty
  a_rem_fwd: assert property (p_rem_fwd) else $error("remote forward while off");

  property p_rsvd;
    @(posedge clk_in) disable iff (sys_rst_in)
      reg_rd_in |=> reg_rvalid_out && reg_rdata_out[13:12] == 2'h0 && !reg_rdata_out[3];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");
endmodule // wake_cfg_reg

// ===== tb/mgmt_host_model.sv
// Station management host model: single-cycle write and read strobes.
// Assumes the bank answers a read one cycle after the strobe.
`timescale 1ns/100ps
module mgmt_host_model
(
  input  wire logic        clk_in,
  output logic [4:0]       reg_addr_out,
  output logic             reg_wr_out,
  output logic [15:0]      reg_wdata_out,
  output logic             reg_rd_out,
  input  wire logic [15:0] reg_rdata_in,
  input  wire logic        reg_rvalid_in
);
  initial
  begin
    reg_addr_out  = 5'h00;
    reg_wr_out    = 1'b0;
    reg_wdata_out = 16'h0000;
    reg_rd_out    = 1'b0;
  end
  // Released data lines show the inverse of the last word
  task automatic write_word(input logic [4:0] addr, input logic [15:0] data);
    @(negedge clk_in);
    reg_addr_out  = addr;
    reg_wdata_out = data;
    reg_wr_out    = 1'b1;
    @(negedge clk_in);
    reg_wr_out    = 1'b0;
    reg_wdata_out = ~data;
  endtask
  task automatic read_word(input logic [4:0] addr, output logic [15:0] data,
                           output logic ok);
    @(negedge clk_in);
    reg_addr_out = addr;
    reg_rd_out   = 1'b1;
    @(negedge clk_in);
    reg_rd_out   = 1'b0;
    ok           = reg_rvalid_in;
    data         = reg_rdata_in;
  endtask
endmodule // mgmt_host_model

// ===== tb/phy_config_register_one_bench.sv
// Self-checking bench for the wake and interface configuration register.
// Assumes the host model drives the register strobes.
`include "wake_cfg_map.svh"
`timescale 1ns/100ps
module phy_config_register_one_bench;
  import wake_cfg_pkg::*;
  logic clk_in, sys_rst_in, wr, rd, rvalid, strap_m, loc_w, rem_w, slp, trf;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata;
  host_if_e    strap_h, host_if;
  logic        role, refc, drv, conf, lpsd, ack, apwd, lpsa;
  logic        loc_ev, rem_ev, loc_fw, rem_fw, ret_n;
  int          bad_count, n_tests;
  wire  [15:0] dec = {role, 5'h00, host_if, drv, conf, lpsd, ack, 2'h0, apwd, lpsa};

  mgmt_host_model host (.clk_in(clk_in), .reg_addr_out(addr), .reg_wr_out(wr),
    .reg_wdata_out(wdata), .reg_rd_out(rd), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid));
  wake_cfg_reg dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd), .strap_master_in(strap_m),
    .strap_host_if_in(strap_h), .local_wake_in(loc_w), .remote_wake_in(rem_w),
    .sleep_req_mode_in(slp), .traffic_in(trf), .reg_rdata_out(rdata),
    .reg_rvalid_out(rvalid), .master_role_out(role), .host_if_out(host_if),
    .ref_clk_out_en_out(refc), .reduced_drive_out(drv),
    .sleep_peer_confirm_required_out(conf), .low_power_symbol_disable_out(lpsd),
    .sleep_ack_timer_run_out(ack), .auto_pwd_out(apwd), .lps_active_out(lpsa),
    .local_wake_event_out(loc_ev), .remote_wake_event_out(rem_ev),
    .local_wake_forward_out(loc_fw), .remote_wake_forward_out(rem_fw),
    .traffic_return_normal_out(ret_n));

  initial
  begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic        ok;
    host.read_word(a, d, ok);
    check("rvalid", 16'h0001, {15'h0, ok});
    check("rdata", exp, d);
  endtask
  task automatic settle();
    repeat (3) @(negedge clk_in);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    rd_chk(5'h12, 16'hcd01);
    settle();
    check("decoded", 16'h8101, dec);
    rd_chk(5'h11, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_fields();
    logic [15:0] v;
    for (int i = 0; i < 4; i++)
    begin
      v = (i[0] ? 16'hfcff : 16'h0000) | (16'(i) << 8);
      host.write_word(5'h12, v);
      rd_chk(5'h12, v & `CFG1_WMASK);
      settle();
      check("decoded", v & 16'h83f3, dec);
      check("refclk", {15'h0, i == 2}, {15'h0, refc});
    end
    host.write_word(5'h11, 16'h0000);
    rd_chk(5'h12, 16'hcff7);
    $display("test fields done");
  endtask
  task automatic t_local();
    host.write_word(5'h12, 16'h4800);
    loc_w = 1'b1;
    settle();
    check("loc_ev", 16'h0000, {15'h0, loc_ev});
    loc_w = 1'b0;
    host.write_word(5'h12, 16'h4c00);
    loc_w = 1'b1;
    repeat (`WAKE_DET_CYCLES) @(negedge clk_in);
    check("loc_ev", 16'h0000, {15'h0, loc_ev});
    repeat (3) @(negedge clk_in);
    check("loc_ev", 16'h0001, {15'h0, loc_ev});
    check("loc_fw", 16'h0001, {15'h0, loc_fw});
    host.write_word(5'h12, 16'h0c00);
    settle();
    check("loc_fw", 16'h0000, {15'h0, loc_fw});
    loc_w = 1'b0;
    $display("test local wake done");
  endtask
  task automatic t_remote();
    host.write_word(5'h12, 16'h0000);
    rem_w = 1'b1;
    settle();
    check("rem_ev", 16'h0000, {15'h0, rem_ev});
    host.write_word(5'h12, 16'h0800);
    settle();
    check("rem_ev", 16'h0001, {15'h0, rem_ev});
    check("rem_fw", 16'h0000, {15'h0, rem_fw});
    host.write_word(5'h12, 16'h0804);
    settle();
    check("rem_fw", 16'h0001, {15'h0, rem_fw});
    rem_w = 1'b0;
    $display("test remote wake done");
  endtask
  task automatic t_traffic();
    slp = 1'b1;
    trf = 1'b1;
    host.write_word(5'h12, 16'h0000);
    settle();
    check("ret_n", 16'h0001, {15'h0, ret_n});
    host.write_word(5'h12, 16'h0010);
    settle();
    check("ret_n", 16'h0000, {15'h0, ret_n});
    check("ack", 16'h0001, {15'h0, ack});
    $display("test traffic done");
  endtask
  task automatic t_restrap();
    strap_m    = 1'b0;
    strap_h    = HOST_REV_MII;
    sys_rst_in = 1'b1;
    repeat (3) @(negedge clk_in);
    check("rst_dec", 16'h0000, dec);
    sys_rst_in = 1'b0;
    repeat (2) @(negedge clk_in);
    rd_chk(5'h12, 16'h4f01);
    settle();
    check("decoded", 16'h0301, dec);
    $display("test strap reload done");
  endtask

  initial
  begin
    bad_count  = 0;
    n_tests    = 0;
    sys_rst_in = 1'b1;
    strap_m    = 1'b1;
    strap_h    = HOST_RMII_IN50;
    loc_w      = 1'b0;
    rem_w      = 1'b0;
    slp        = 1'b0;
    trf        = 1'b0;
    repeat (10) @(negedge clk_in);
    sys_rst_in = 1'b0;
    repeat (2) @(negedge clk_in);
    t_reset();
    t_fields();
    repeat (50) @(negedge clk_in);
    t_local();
    t_remote();
    t_traffic();
    t_restrap();
    stop_test();
  end

  initial
  begin
    repeat (5000) @(posedge clk_in);
    bad_count++;
    stop_test();
  end
endmodule // phy_config_register_one_bench
